// ---- rtl/sdct_ctrl.sv ----
// Host-side LPDDR command sequencer that keeps the device timing
// Summary of operation
// - Activates to different banks at least 10 ns apart
// - Read waits two CK after last write beat
// - Column commands may follow every CK; here a read or write waits until the previous burst ends
// - Two CK after mode register set
// - Two CK after power-down exit before command
// - Clock enable holds each level two CK
// - 120 ns after auto refresh before anything
// - 120 ns after self refresh exit before activate
// - Deep power-down lasts at least 500 us
// - Write strobe low preamble before first edge
// - Write strobe postamble low 0.4 to 0.6 CK
// - Clock change only outside normal operation
// - At most eight refreshes per burst
`timescale 1ns/1ps
`default_nettype none
`include "sdct_defines.svh"

module sdct_ctrl #(
  parameter int DQW = 32,
  parameter int BL = 4,
  parameter int CL = 3,
  parameter int T_DPD_CYC = `SDCT_T_DPD_CK
) (
  input wire logic clk,
  input wire logic rst,
  // User command side
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire sdct_pkg::sdct_cmd_t cmd_code,
  input wire logic [1:0] cmd_bank,
  input wire logic [13:0] cmd_addr,
  output logic cmd_done,
  output logic cmd_err,
  output logic clk_change_ok,
  // Write burst data loading
  input wire logic wbuf_we,
  input wire logic [$clog2(BL)-1:0] wbuf_addr,
  input wire logic [DQW-1:0] wbuf_data,
  // Read data return
  output logic rd_valid,
  output logic [DQW-1:0] rd_data,
  output logic rd_strobe,
  // Memory pins
  output logic ck_p,
  output logic ck_n,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [1:0] ba,
  output logic [13:0] a,
  input wire logic [DQW-1:0] dq_in,
  output logic [DQW-1:0] dq_out,
  output logic dq_oe_n,
  input wire logic dqs_in,
  output logic dqs_out,
  output logic dqs_oe_n
);

  localparam int AW = $clog2(BL);
  localparam int CW = 4;
  localparam int DPDW = $clog2(T_DPD_CYC + 1);
  localparam int WPRE_LEN = `SDCT_T_WPRE_HALF + `SDCT_DQSS_HALF;
  localparam int RWAIT = 2 * CL + 3;

  // Counter loads: a counter loaded with N-1 at a tick frees the N-th tick
  localparam logic [CW-1:0] L_RRD = CW'(`SDCT_T_RRD_CK - 1);
  localparam logic [CW-1:0] L_MRD = CW'(`SDCT_T_MRD_CK - 1);
  localparam logic [CW-1:0] L_PDEX = CW'(`SDCT_T_PDEX_CK - 1);
  localparam logic [CW-1:0] L_CKE = CW'(`SDCT_T_CKE_CK - 1);
  localparam logic [CW-1:0] L_RFC = CW'(`SDCT_T_RFC_CK - 1);
  localparam logic [CW-1:0] L_XSR = CW'(`SDCT_T_XSR_CK - 1);
  localparam logic [CW-1:0] L_CDLR = CW'(`SDCT_T_CDLR_CK);
  localparam logic [CW-1:0] L_CCD = CW'(`SDCT_T_CCD_CK - 1);
  localparam logic [DPDW-1:0] L_DPD = DPDW'(T_DPD_CYC - 1);
  localparam logic [3:0] REF_MAX = 4'(`SDCT_REF_BURST_MAX);

  // Elaboration checks
  if (BL != 2 && BL != 4 && BL != 8 && BL != 16) begin : g_bl_chk
    $error("sdct_ctrl: burst length must be 2, 4, 8 or 16");
  end
  if (CL < 2 || CL > 3) begin : g_cl_chk
    $error("sdct_ctrl: CAS latency must be 2 or 3");
  end
  if (T_DPD_CYC < 1 || `SDCT_T_WPST_HALF != 1) begin : g_t_chk
    $error("sdct_ctrl: timing set not supported");
  end

  typedef struct packed {
    logic ph;
    logic ckn;
    logic cke;
    logic [3:0] pins;
    logic [1:0] ba;
    logic [13:0] a;
    logic pend_v;
    sdct_pkg::sdct_cmd_t pend_cmd;
    logic [1:0] pend_ba;
    logic [13:0] pend_a;
    sdct_pkg::sdct_cmd_t icmd;
    logic cmd_ready;
    logic cmd_done;
    logic cmd_err;
    logic clk_change_ok;
    sdct_pkg::sdct_pwr_t pwr;
    logic [CW-1:0] c_rrd;
    logic [CW-1:0] c_gen;
    logic [CW-1:0] c_rdblk;
    logic [CW-1:0] c_cke;
    logic [CW-1:0] c_xsr;
    logic [DPDW-1:0] c_dpd;
    logic [3:0] ref_run;
    sdct_pkg::sdct_wph_t wph;
    logic [CW-1:0] wcnt;
    logic [AW:0] wbeat;
    logic [DQW-1:0] dq_out;
    logic dq_oe_n;
    logic dqs_out;
    logic dqs_oe_n;
    logic ract;
    logic [5:0] rwait;
    logic [AW:0] rbeat;
    logic rd_valid;
    logic [DQW-1:0] rd_data;
    logic rd_strobe;
    logic [DQW:0] sync1;
    logic [DQW:0] sync2;
  } sdct_state_t;

  sdct_state_t st;
  sdct_state_t next_st;
  logic tick;
  logic [DQW-1:0] wb_rdata;

  // Pin pattern for each command
  function automatic logic [3:0] pins_of(sdct_pkg::sdct_cmd_t c);
    unique case (c)
      sdct_pkg::CMD_ACT: pins_of = `SDCT_PIN_ACT;
      sdct_pkg::CMD_RD: pins_of = `SDCT_PIN_RD;
      sdct_pkg::CMD_WR: pins_of = `SDCT_PIN_WR;
      sdct_pkg::CMD_PRE: pins_of = `SDCT_PIN_PRE;
      sdct_pkg::CMD_MRS: pins_of = `SDCT_PIN_MRS;
      sdct_pkg::CMD_REF: pins_of = `SDCT_PIN_REF;
      sdct_pkg::CMD_SRE: pins_of = `SDCT_PIN_REF;
      sdct_pkg::CMD_DPDE: pins_of = `SDCT_PIN_DPD;
      sdct_pkg::CMD_PDE: pins_of = `SDCT_PIN_NOP;
      sdct_pkg::CMD_PDX: pins_of = `SDCT_PIN_NOP;
      sdct_pkg::CMD_SRX: pins_of = `SDCT_PIN_NOP;
      sdct_pkg::CMD_DPDX: pins_of = `SDCT_PIN_NOP;
    endcase
  endfunction : pins_of

  // Counter step taken once per CK
  function automatic logic [CW-1:0] dec(logic [CW-1:0] v);
    dec = (v != '0) ? v - CW'(1) : v;
  endfunction : dec

  // Pins change as CK falls, so the device sees them at the next rise
  assign tick = st.ph;

  sdct_wbuf #(
    .W(DQW),
    .DEPTH(BL)
  ) u_wbuf (
    .clk(clk),
    .we(wbuf_we),
    .waddr(wbuf_addr),
    .wdata(wbuf_data),
    .raddr(next_st.wbeat[AW-1:0]),
    .rdata(wb_rdata)
  );

  // Next state
  always_comb begin
    logic wbusy;
    logic rbusy;
    logic legal;
    logic ready_now;
    wbusy = 1'b0;
    rbusy = 1'b0;
    legal = 1'b0;
    ready_now = 1'b0;
    next_st = st;
    wbusy = (st.wph != sdct_pkg::W_IDLE);
    rbusy = st.ract;
    next_st.ph = ~st.ph;
    next_st.ckn = st.ph;
    next_st.cmd_done = 1'b0;
    next_st.cmd_err = 1'b0;
    next_st.rd_valid = 1'b0;
    // Pins pass two flops before anything reads them
    next_st.sync1 = {dqs_in, dq_in};
    next_st.sync2 = st.sync1;

    // Take one request into the pending slot
    if (cmd_valid && st.cmd_ready) begin
      next_st.pend_v = 1'b1;
      next_st.pend_cmd = cmd_code;
      next_st.pend_ba = cmd_bank;
      next_st.pend_a = cmd_addr;
    end

    // Read return: beats counted from the command, no strobe tracking
    if (st.ract) begin
      if (st.rwait != 6'h00) begin
        next_st.rwait = st.rwait - 6'h01;
      end else begin
        next_st.rd_valid = 1'b1;
        next_st.rd_data = st.sync2[DQW-1:0];
        next_st.rd_strobe = st.sync2[DQW];
        next_st.rbeat = st.rbeat + (AW + 1)'(1);
        if (st.rbeat == (AW + 1)'(BL - 1)) begin
          next_st.ract = 1'b0;
        end
      end
    end

    // Write strobe framing
    unique case (st.wph)
      sdct_pkg::W_IDLE: begin
      end
      sdct_pkg::W_PRE: begin
        if (st.wcnt != '0) begin
          next_st.wcnt = st.wcnt - CW'(1);
        end else begin
          next_st.wph = sdct_pkg::W_DATA;
          next_st.dq_oe_n = 1'b0;
          next_st.dq_out = wb_rdata;
          next_st.dqs_out = 1'b1;
          next_st.wbeat = st.wbeat + (AW + 1)'(1);
        end
      end
      sdct_pkg::W_DATA: begin
        if (st.wbeat == (AW + 1)'(BL)) begin
          next_st.wph = sdct_pkg::W_IDLE;
          next_st.dq_oe_n = 1'b1;
          next_st.dqs_oe_n = 1'b1;
          next_st.dqs_out = 1'b0;
          next_st.wbeat = '0;
        end else begin
          next_st.dq_out = wb_rdata;
          next_st.dqs_out = ~st.dqs_out;
          next_st.wbeat = st.wbeat + (AW + 1)'(1);
        end
      end
    endcase

    // One decision per CK; waits count in whole CK
    if (tick) begin
      next_st.pins = `SDCT_PIN_DESEL;
      next_st.c_rrd = dec(st.c_rrd);
      next_st.c_gen = dec(st.c_gen);
      next_st.c_cke = dec(st.c_cke);
      next_st.c_xsr = dec(st.c_xsr);
      next_st.c_rdblk = dec(st.c_rdblk);
      if (st.c_dpd != '0) begin
        next_st.c_dpd = st.c_dpd - DPDW'(1);
      end
      if (st.pend_v) begin
        unique case (st.pend_cmd)
          sdct_pkg::CMD_PDX: begin
            legal = (st.pwr == sdct_pkg::PWR_PDOWN);
            ready_now = (st.c_cke == '0);
          end
          sdct_pkg::CMD_SRX: begin
            legal = (st.pwr == sdct_pkg::PWR_SELF);
            ready_now = (st.c_cke == '0);
          end
          sdct_pkg::CMD_DPDX: begin
            legal = (st.pwr == sdct_pkg::PWR_DEEP);
            ready_now = (st.c_cke == '0) && (st.c_dpd == '0);
          end
          sdct_pkg::CMD_REF: begin
            legal = (st.pwr == sdct_pkg::PWR_ACTIVE) &&
                    (st.ref_run != REF_MAX);
            ready_now = (st.c_gen == '0);
          end
          sdct_pkg::CMD_ACT: begin
            legal = (st.pwr == sdct_pkg::PWR_ACTIVE);
            ready_now = (st.c_gen == '0) && (st.c_rrd == '0) &&
                        (st.c_xsr == '0);
          end
          sdct_pkg::CMD_RD: begin
            legal = (st.pwr == sdct_pkg::PWR_ACTIVE);
            ready_now = (st.c_gen == '0) && (st.c_rdblk == '0) &&
                        !wbusy && !rbusy;
          end
          sdct_pkg::CMD_WR: begin
            legal = (st.pwr == sdct_pkg::PWR_ACTIVE);
            ready_now = (st.c_gen == '0) && !wbusy && !rbusy;
          end
          sdct_pkg::CMD_PRE, sdct_pkg::CMD_MRS: begin
            legal = (st.pwr == sdct_pkg::PWR_ACTIVE);
            ready_now = (st.c_gen == '0);
          end
          sdct_pkg::CMD_PDE, sdct_pkg::CMD_SRE, sdct_pkg::CMD_DPDE: begin
            legal = (st.pwr == sdct_pkg::PWR_ACTIVE);
            ready_now = (st.c_gen == '0) && (st.c_cke == '0) &&
                        !wbusy && !rbusy;
          end
        endcase
        if (!legal) begin
          next_st.pend_v = 1'b0;
          next_st.cmd_err = 1'b1;
        end else if (ready_now) begin
          next_st.pend_v = 1'b0;
          next_st.cmd_done = 1'b1;
          next_st.icmd = st.pend_cmd;
          next_st.pins = pins_of(st.pend_cmd);
          next_st.ba = st.pend_ba;
          next_st.a = st.pend_a;
          if (st.pend_cmd != sdct_pkg::CMD_REF) begin
            next_st.ref_run = 4'h0;
          end
          unique case (st.pend_cmd)
            sdct_pkg::CMD_ACT: next_st.c_rrd = L_RRD;
            // c_gen frees the next CK; RD and WR wait until the read or write burst ends
            sdct_pkg::CMD_RD: begin
              next_st.c_gen = L_CCD;
              next_st.ract = 1'b1;
              next_st.rwait = 6'(RWAIT);
              next_st.rbeat = '0;
            end
            sdct_pkg::CMD_WR: begin
              next_st.c_gen = L_CCD;
              next_st.wph = sdct_pkg::W_PRE;
              next_st.wcnt = CW'(WPRE_LEN - 1);
              next_st.wbeat = '0;
              next_st.dqs_oe_n = 1'b0;
              next_st.dqs_out = 1'b0;
            end
            sdct_pkg::CMD_PRE: begin
            end
            sdct_pkg::CMD_MRS: next_st.c_gen = L_MRD;
            sdct_pkg::CMD_REF: begin
              next_st.c_gen = L_RFC;
              next_st.ref_run = st.ref_run + 4'h1;
            end
            sdct_pkg::CMD_PDE, sdct_pkg::CMD_SRE: begin
              next_st.cke = 1'b0;
              next_st.c_cke = L_CKE;
              next_st.pwr = (st.pend_cmd == sdct_pkg::CMD_PDE) ?
                            sdct_pkg::PWR_PDOWN : sdct_pkg::PWR_SELF;
            end
            sdct_pkg::CMD_DPDE: begin
              next_st.cke = 1'b0;
              next_st.c_cke = L_CKE;
              next_st.c_dpd = L_DPD;
              next_st.pwr = sdct_pkg::PWR_DEEP;
            end
            sdct_pkg::CMD_PDX: begin
              next_st.cke = 1'b1;
              next_st.c_cke = L_CKE;
              next_st.c_gen = L_PDEX;
              next_st.pwr = sdct_pkg::PWR_ACTIVE;
            end
            sdct_pkg::CMD_SRX: begin
              next_st.cke = 1'b1;
              next_st.c_cke = L_CKE;
              next_st.c_xsr = L_XSR;
              next_st.pwr = sdct_pkg::PWR_ACTIVE;
            end
            sdct_pkg::CMD_DPDX: begin
              next_st.cke = 1'b1;
              next_st.c_cke = L_CKE;
              next_st.pwr = sdct_pkg::PWR_ACTIVE;
            end
          endcase
        end
      end
    end

    // Turnaround starts once the write strobe is let go
    if (st.wph == sdct_pkg::W_DATA && next_st.wph == sdct_pkg::W_IDLE) begin
      next_st.c_rdblk = L_CDLR;
    end
    next_st.cmd_ready = !next_st.pend_v;
    next_st.clk_change_ok = (next_st.pwr == sdct_pkg::PWR_PDOWN) ||
                            (next_st.pwr == sdct_pkg::PWR_SELF);
  end

  // State register; memory starts powered with clock enable high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.ckn <= 1'b1;
      st.cke <= 1'b1;
      st.pins <= `SDCT_PIN_DESEL;
      st.cmd_ready <= 1'b1;
      st.pwr <= sdct_pkg::PWR_ACTIVE;
      st.wph <= sdct_pkg::W_IDLE;
      st.dq_oe_n <= 1'b1;
      st.dqs_oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign cmd_ready = st.cmd_ready;
  assign cmd_done = st.cmd_done;
  assign cmd_err = st.cmd_err;
  assign clk_change_ok = st.clk_change_ok;
  assign rd_valid = st.rd_valid;
  assign rd_data = st.rd_data;
  assign rd_strobe = st.rd_strobe;
  assign ck_p = st.ph;
  assign ck_n = st.ckn;
  assign cke = st.cke;
  assign {cs_n, ras_n, cas_n, we_n} = st.pins;
  assign ba = st.ba;
  assign a = st.a;
  assign dq_out = st.dq_out;
  assign dq_oe_n = st.dq_oe_n;
  assign dqs_out = st.dqs_out;
  assign dqs_oe_n = st.dqs_oe_n;

  // Assertion helpers: clk cycles since events, saturating
  logic [7:0] gap;
  logic [7:0] since_wl;
  logic [7:0] since_srx;
  logic [DPDW+1:0] dpd_len;
  sdct_pkg::sdct_cmd_t prev_cmd;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap <= 8'hFF;
      since_wl <= 8'hFF;
      since_srx <= 8'hFF;
      dpd_len <= '0;
      prev_cmd <= sdct_pkg::CMD_PRE;
    end else begin
      gap <= st.cmd_done ? 8'h00 : (gap == 8'hFF ? gap : gap + 8'h01);
      prev_cmd <= st.cmd_done ? st.icmd : prev_cmd;
      since_wl <= ($rose(st.dqs_oe_n)) ? 8'h00 :
                  (since_wl == 8'hFF ? since_wl : since_wl + 8'h01);
      since_srx <= (st.cmd_done && st.icmd == sdct_pkg::CMD_SRX) ? 8'h00 :
                   (since_srx == 8'hFF ? since_srx : since_srx + 8'h01);
      dpd_len <= (st.cmd_done && st.icmd == sdct_pkg::CMD_DPDE) ? '0 :
                 (&dpd_len ? dpd_len : dpd_len + (DPDW + 2)'(1));
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  act_gap_a: assert property (
    st.cmd_done && st.icmd == sdct_pkg::CMD_ACT &&
    prev_cmd == sdct_pkg::CMD_ACT |-> gap >= 8'(2 * `SDCT_T_RRD_CK - 1))
    else $error("activates too close");
  wr_rd_gap_a: assert property (
    st.cmd_done && st.icmd == sdct_pkg::CMD_RD |->
    since_wl >= 8'(2 * `SDCT_T_CDLR_CK))
    else $error("read too soon after write data");
  col_gap_a: assert property (
    st.cmd_done |=> !st.cmd_done)
    else $error("two commands within one CK");
  mrs_gap_a: assert property (
    st.cmd_done && prev_cmd == sdct_pkg::CMD_MRS |->
    gap >= 8'(2 * `SDCT_T_MRD_CK - 1))
    else $error("command too soon after mode set");
  pdx_gap_a: assert property (
    st.cmd_done && prev_cmd == sdct_pkg::CMD_PDX |->
    gap >= 8'(2 * `SDCT_T_PDEX_CK - 1))
    else $error("command too soon after power-down exit");
  cke_hold_a: assert property (
    $changed(st.cke) |=> $stable(st.cke) [*3])
    else $error("clock enable pulse too short");
  rfc_gap_a: assert property (
    st.cmd_done && prev_cmd == sdct_pkg::CMD_REF |->
    gap >= 8'(2 * `SDCT_T_RFC_CK - 1))
    else $error("command too soon after refresh");
  xsr_gap_a: assert property (
    st.cmd_done && st.icmd == sdct_pkg::CMD_ACT |->
    since_srx >= 8'(2 * `SDCT_T_XSR_CK - 1))
    else $error("activate too soon after self refresh exit");
  dpd_len_a: assert property (
    st.cmd_done && st.icmd == sdct_pkg::CMD_DPDX |->
    dpd_len >= (DPDW + 2)'(2 * T_DPD_CYC - 1))
    else $error("deep power-down left too early");
  wr_pre_a: assert property (
    $fell(st.dqs_oe_n) |-> (!st.dqs_out) [*3] ##1 st.dqs_out)
    else $error("write preamble wrong");
  wr_post_a: assert property (
    $rose(st.dqs_oe_n) |-> !$past(st.dqs_out) && $past(st.dqs_out, 2))
    else $error("write postamble wrong");
  clk_chg_a: assert property (
    st.clk_change_ok |-> !st.cke)
    else $error("clock change allowed while running");
  ref_burst_a: assert property (
    st.ref_run <= REF_MAX)
    else $error("refresh burst too long");

endmodule : sdct_ctrl

`default_nettype wire

// ---- shared/sdct_defines.svh ----
// Timing constants and pin encodings for the SDRAM command timing controller
`ifndef SDCT_DEFINES_SVH
`define SDCT_DEFINES_SVH

// Round a time up to whole cycles of a given period
`define SDCT_CEIL(n, d) (((n) + (d) - 1) / (d))

// System clock and derived memory clock (CK is clk divided by two)
`define SDCT_CLK_NS 10
`define SDCT_CK_DIV 2
`define SDCT_TCK_NS (`SDCT_CLK_NS * `SDCT_CK_DIV)

// Activate to activate, different banks
`define SDCT_T_RRD_NS 10
`define SDCT_T_RRD_CK `SDCT_CEIL(`SDCT_T_RRD_NS, `SDCT_TCK_NS)
// Last write data in to read command, in CK
`define SDCT_T_CDLR_CK 2
// Column to column command spacing, in CK
`define SDCT_T_CCD_CK 1
// Mode register set cycle, in CK
`define SDCT_T_MRD_CK 2
// Power-down exit, in CK
`define SDCT_T_PDEX_CK 2
// Clock enable least pulse width, in CK
`define SDCT_T_CKE_CK 2
// Auto refresh cycle
`define SDCT_T_RFC_NS 120
`define SDCT_T_RFC_CK `SDCT_CEIL(`SDCT_T_RFC_NS, `SDCT_TCK_NS)
// Self refresh exit to activate
`define SDCT_T_XSR_NS 120
`define SDCT_T_XSR_CK `SDCT_CEIL(`SDCT_T_XSR_NS, `SDCT_TCK_NS)
// Deep power-down least stay
`define SDCT_T_DPD_US 500
`define SDCT_T_DPD_CK `SDCT_CEIL(`SDCT_T_DPD_US * 1000, `SDCT_TCK_NS)
// Write preamble, hundredths of CK, turned into CK half periods
`define SDCT_T_WPRE_CENTI 25
`define SDCT_T_WPRE_HALF `SDCT_CEIL(`SDCT_T_WPRE_CENTI * 2, 100)
// Extra preamble so the first strobe rise lands one CK after the command
`define SDCT_DQSS_HALF 2
// Write postamble window, hundredths of CK, and the half periods used
`define SDCT_T_WPST_MIN_CENTI 40
`define SDCT_T_WPST_MAX_CENTI 60
`define SDCT_T_WPST_HALF ((`SDCT_T_WPST_MAX_CENTI * 2) / 100)
// Longest run of back to back refreshes
`define SDCT_REF_BURST_MAX 8

// Pin patterns {cs_n, ras_n, cas_n, we_n}
`define SDCT_PIN_DESEL 4'hF
`define SDCT_PIN_NOP 4'h7
`define SDCT_PIN_ACT 4'h3
`define SDCT_PIN_RD 4'h5
`define SDCT_PIN_WR 4'h4
`define SDCT_PIN_PRE 4'h2
`define SDCT_PIN_MRS 4'h0
`define SDCT_PIN_REF 4'h1
`define SDCT_PIN_DPD 4'h6

`endif

// ---- shared/sdct_pkg.sv ----
// Types shared by the SDRAM command timing controller
package sdct_pkg;

  // Commands the user side may request
  typedef enum logic [3:0] {
    CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_MRS, CMD_REF,
    CMD_PDE, CMD_PDX, CMD_SRE, CMD_SRX, CMD_DPDE, CMD_DPDX
  } sdct_cmd_t;

  // Power state of the memory as the controller has left it
  typedef enum logic [1:0] {
    PWR_ACTIVE, PWR_PDOWN, PWR_SELF, PWR_DEEP
  } sdct_pwr_t;

  // Write strobe framing phase
  typedef enum logic [1:0] {
    W_IDLE, W_PRE, W_DATA
  } sdct_wph_t;

endpackage : sdct_pkg

// ---- rtl/sdct_wbuf.sv ----
// Write burst data store with registered read
`timescale 1ns/1ps
`default_nettype none

module sdct_wbuf #(
  parameter int W = 32,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [W-1:0] rdata
);

  logic [W-1:0] mem [DEPTH];

  // Elaboration check on the depth
  if (DEPTH < 2) begin : g_chk
    $error("sdct_wbuf: depth below two");
  end

  // No reset on the array; read data always from a register
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : sdct_wbuf

`default_nettype wire

// ---- verif/sdct_mem.sv ----
// Behavioural memory device that checks the controller's timing
`timescale 1ns/1ps
`default_nettype none
`include "sdct_defines.svh"
module sdct_mem #(
  parameter int CL = 3,
  parameter int T_DPD = 20
) (
  input wire logic clk,
  input wire logic ck_p,
  input wire logic cke,
  input wire logic [3:0] p,
  input wire logic [31:0] dq_out,
  input wire logic dq_oe_n,
  input wire logic dqs_out,
  input wire logic dqs_oe_n,
  output logic [31:0] dq_in,
  output int viol
);
  logic [31:0] mem [0:3];
  logic ck_q, doe_q, dqs_q, soe_q;
  int ck, tc, wi;
  int tk = -99;
  int tw = -99;
  int ts = -99;
  int nref, rc;
  logic [3:0] lc;
  initial begin
    ck_q = 1;
    dq_in = '0;
    rc = 99;
  end
  // Beats on both CK edges; idle bus toggles so stale data never matches
  always @(ck_p) begin
    rc++;
    dq_in = (rc >= 2*CL && rc < 2*CL+4) ? mem[rc-2*CL] : ~dq_in;
    if (ck_p) begin
      ck++;
      if (cke !== ck_q) begin
        if (ck - tk < `SDCT_T_CKE_CK) viol++;
        if (cke && lc == `SDCT_PIN_DPD && ck - tc < T_DPD) viol++;
        if (cke && lc == `SDCT_PIN_REF) ts = ck;
        tk = ck;
        ck_q = cke;
      end
      if (!p[3] && p != `SDCT_PIN_NOP) begin
        if (lc == `SDCT_PIN_MRS && ck - tc < `SDCT_T_MRD_CK) viol++;
        if (lc == `SDCT_PIN_REF && ck - tc < `SDCT_T_RFC_CK) viol++;
        if (cke && ck - tk < `SDCT_T_PDEX_CK) viol++;
        if (p == `SDCT_PIN_ACT && ck - ts < `SDCT_T_XSR_CK) viol++;
        if (p == `SDCT_PIN_RD && ck - tw < `SDCT_T_CDLR_CK) viol++;
        nref = (p == `SDCT_PIN_REF) ? nref + 1 : 0;
        if (nref > `SDCT_REF_BURST_MAX) viol++;
        if (p == `SDCT_PIN_WR) wi = 0;
        if (p == `SDCT_PIN_RD) rc = 0;
        lc = p;
        tc = ck;
      end
    end
  end
  // Write capture; strobe framing
  always @(posedge clk) begin
    if (!dq_oe_n) begin
      mem[wi%4] = dq_out;
      wi++;
      tw = ck;
    end
    if (!dq_oe_n && doe_q && (soe_q || dqs_q)) viol++;
    if (dq_oe_n && !doe_q && !(dqs_oe_n && !dqs_q)) viol++;
    doe_q = dq_oe_n;
    dqs_q = dqs_out;
    soe_q = dqs_oe_n;
  end
endmodule : sdct_mem
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the command timing controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 0;
  logic rst = 1;
  logic cmd_valid = 0;
  logic wbuf_we = 0;
  sdct_pkg::sdct_cmd_t cmd_code = sdct_pkg::CMD_PRE;
  logic [1:0] cmd_bank = '0;
  logic [1:0] wbuf_addr = '0;
  logic [31:0] wbuf_data = '0;
  logic cmd_ready, cmd_done, cmd_err, clk_change_ok, rd_valid, rd_strobe;
  logic ck_p, ck_n, cke, cs_n, ras_n, cas_n, we_n, dq_oe_n, dqs_out;
  logic dqs_oe_n;
  logic [1:0] ba;
  logic [13:0] a;
  logic [31:0] rd_data, dq_in, dq_out;
  int viol, n_fail, tests_run, t0;
  always #5 clk = ~clk;
  // Read strobe follows CK, edge aligned as the device returns it
  sdct_ctrl #(.T_DPD_CYC(20)) i_dut (.clk, .rst, .cmd_valid, .cmd_ready,
    .cmd_code, .cmd_bank, .cmd_addr(14'h0155), .cmd_done, .cmd_err,
    .clk_change_ok, .wbuf_we, .wbuf_addr, .wbuf_data, .rd_valid, .rd_data,
    .rd_strobe, .ck_p, .ck_n, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .a,
    .dq_in, .dq_out, .dq_oe_n, .dqs_in(ck_p), .dqs_out, .dqs_oe_n);
  sdct_mem #(.CL(3), .T_DPD(20)) i_mem (.clk, .ck_p, .cke,
    .p({cs_n, ras_n, cas_n, we_n}), .dq_out, .dq_oe_n, .dqs_out, .dqs_oe_n,
    .dq_in, .viol);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic finish_test;
    $display("fails=%0d checks=%0d", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test
  // Offer one command, hold it until taken, then judge the answer
  task automatic issue(input sdct_pkg::sdct_cmd_t c, input logic e);
    int k;
    k = 0;
    cmd_valid = 1;
    cmd_code = c;
    cmd_bank = cmd_bank + 2'h1;
    // Ready read between edges; the following edge takes the request
    while (cmd_ready !== 1'b1 && k < 3000) begin
      @(posedge clk);
      #1 k++;
    end
    @(posedge clk);
    #1 cmd_valid = 0;
    while (cmd_done !== 1'b1 && cmd_err !== 1'b1 && k < 3000) begin
      @(posedge clk);
      #1 k++;
    end
    if (k >= 3000) begin
      n_fail++;
      finish_test();
    end
    chk(cmd_err, e);
    if (cmd_done === 1'b1) begin
      chk({ba, a}, {cmd_bank, 14'h0155});
    end
    chk(ck_n, !ck_p);
  endtask : issue
  // Burst write then read back, beats in order
  task automatic t_wr_rd;
    int k;
    for (int i = 0; i < 4; i++) begin
      wbuf_we = 1;
      wbuf_addr = i[1:0];
      wbuf_data = 32'hA5C30000 | i;
      @(posedge clk);
      #1;
    end
    wbuf_we = 0;
    issue(sdct_pkg::CMD_WR, 0);
    issue(sdct_pkg::CMD_RD, 0);
    k = 0;
    for (int i = 0; i < 4 && k < 60; k++) begin
      @(posedge clk);
      #1;
      if (rd_valid === 1'b1) begin
        chk(rd_data, 32'hA5C30000 | i);
        chk(rd_strobe, i % 2 == 0);
        i++;
      end
    end
    chk(k < 60, 1);
    if (k >= 60) begin
      finish_test();
    end
  endtask : t_wr_rd
  // Refresh burst limit, then low-power states
  task automatic t_power;
    for (int i = 0; i < 9; i++) issue(sdct_pkg::CMD_REF, i == 8);
    issue(sdct_pkg::CMD_PRE, 0);
    issue(sdct_pkg::CMD_PDX, 1);
    issue(sdct_pkg::CMD_PDE, 0);
    chk(clk_change_ok, 1);
    issue(sdct_pkg::CMD_PDX, 0);
    chk(clk_change_ok, 0);
    issue(sdct_pkg::CMD_ACT, 0);
    issue(sdct_pkg::CMD_SRE, 0);
    chk(clk_change_ok, 1);
    issue(sdct_pkg::CMD_SRX, 0);
    chk(clk_change_ok, 0);
    issue(sdct_pkg::CMD_ACT, 0);
    issue(sdct_pkg::CMD_DPDE, 0);
    t0 = $time;
    issue(sdct_pkg::CMD_DPDX, 0);
    chk($time - t0 >= 400, 1);
  endtask : t_power
  initial begin
    repeat (8) @(posedge clk);
    #1 rst = 0;
    issue(sdct_pkg::CMD_MRS, 0);
    issue(sdct_pkg::CMD_ACT, 0);
    issue(sdct_pkg::CMD_ACT, 0);
    t_wr_rd();
    t_power();
    repeat (20) @(posedge clk);
    chk(viol, 0);
    finish_test();
  end
endmodule : testbench
`default_nettype wire
